/* test/fbn_master_model.sv */
// Purpose: Bus master and other stations issuing decoded telegrams.
// Assumes: One telegram per call, held for one clock.
// Notes:   Idle fields are scrambled so stale values never look valid.
`timescale 1ns/1ps
module fbn_master_model
  import fbn_pkg::*;
(
  input  wire logic i_clk,
  output fbn_tg_t   o_tg
);
  initial o_tg = '0;

  // Issue one telegram, then release with inverted fields
  task automatic send(input fbn_kind_t k, input logic [7:0] st, input logic [15:0] el,
                      input logic [31:0] wd, input logic crc, input logic m);
    @(posedge i_clk);
    o_tg <= '{1'b1, k, st, el, wd, crc, m};
    @(posedge i_clk);
    o_tg <= {1'b0, ~o_tg[$bits(fbn_tg_t)-2:0]};
  endtask : send
endmodule : fbn_master_model

/* test/fbn_node_properties.sv */
// Purpose: Port-level checks of the field-bus node interpreter.
// Assumes: Own station is tens*10+units of the code switches.
// Notes:   Bound to every fbn_node instance.
`timescale 1ns/1ps
module fbn_node_properties
  import fbn_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire fbn_tg_t    i_tg,
  input wire logic [3:0] i_tens_code_switch,
  input wire logic [3:0] i_units_code_switch,
  input wire logic       i_det_valid,
  input wire logic       i_nvm_load,
  input wire fbn_reply_t o_reply,
  input wire logic [3:0] o_baud_code,
  input wire logic       o_autobaud_en,
  input wire logic       o_nvm_store,
  input wire logic [3:0] o_nvm_code
);
  // ------------------------------------------------------------
  // Telegram classes
  // ------------------------------------------------------------
  wire logic [7:0] own  = 8'(i_tens_code_switch) * 8'h0a + 8'(i_units_code_switch);
  wire logic       mine = i_tg.valid && i_tg.crc_ok && i_tg.station == own;
  wire logic       wreg = mine && i_tg.kind == FBN_WRITE_REGISTER && i_tg.elem == REG_BAUD_RATE_SETTING;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_cause; o_reply.valid |-> $past(i_tg.valid); endproperty
  a_cause: assert property (p_cause) else $error("reply without telegram");
  property p_answer; mine |=> o_reply.valid; endproperty
  a_answer: assert property (p_answer) else $error("own telegram unanswered");
  property p_silent; i_tg.valid && !mine |=> !o_reply.valid; endproperty
  a_silent: assert property (p_silent) else $error("reply to foreign or broadcast");
  property p_nak; o_reply.valid && o_reply.nak |-> o_reply.data == 32'h0000_0000; endproperty
  a_nak: assert property (p_nak) else $error("nak carries data");
  property p_wout; mine && i_tg.kind == FBN_WRITE_OUTPUT |=> o_reply.nak; endproperty
  a_wout: assert property (p_wout) else $error("output write not refused");
  property p_legal; o_baud_code inside {[4'h4:4'h9]}; endproperty
  a_legal: assert property (p_legal) else $error("baud code out of range");
  property p_wbaud; wreg && i_tg.wdata inside {[32'h4:32'h9]} && !i_det_valid
    |=> o_baud_code == 4'($past(i_tg.wdata)); endproperty
  a_wbaud: assert property (p_wbaud) else $error("baud write not applied");
  property p_rst; $fell(i_rst) |-> o_baud_code == BAUD_DEFAULT && !o_autobaud_en; endproperty
  a_rst: assert property (p_rst) else $error("reset baud wrong");
  property p_ab; $rose(o_autobaud_en) |-> $past(i_tg.valid) && !$past(i_tg.crc_ok); endproperty
  a_ab: assert property (p_ab) else $error("recognition armed without error");
  property p_addr; mine && i_tg.kind == FBN_READ_REGISTER && i_tg.elem == REG_STATION_ADDRESS
    |=> o_reply.data == {24'h00_0000, $past(own)}; endproperty
  a_addr: assert property (p_addr) else $error("station address wrong");
  property p_store; $changed(o_baud_code) && !$past(i_nvm_load) && !$past(i_rst)
    |-> o_nvm_store && o_nvm_code == o_baud_code; endproperty
  a_store: assert property (p_store) else $error("rate change not stored");

  // Main scenarios reached
  c_nak: cover property (o_reply.valid && o_reply.nak);
  c_ab: cover property ($rose(o_autobaud_en));
  c_w: cover property (wreg);
  c_store: cover property (o_nvm_store);
endmodule : fbn_node_properties

bind fbn_node fbn_node_properties u_props (.*);

/* test/tb.sv */
// Purpose: Self-checking bench of the field-bus node interpreter.
// Assumes: Own station 23, table rows first, awkward cases after.
// Notes:   Rate recognition limit left at 11.
`timescale 1ns/1ps
module tb
  import fbn_pkg::*;
;
  localparam logic [3:0]  LVL = 4'ha;
  localparam logic [3:0]  MAN = 4'h6;
  localparam logic [33:0] NAK = 34'h3_0000_0000;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [3:0] lvl = LVL;
  logic [3:0] man = MAN;
  logic [3:0] tens = 4'h2;
  logic [3:0] units = 4'h3;
  logic       det_v = 1'b0;
  logic [3:0] det_c = 4'h7;
  logic       nl = 1'b0;
  logic [3:0] nc = 4'h7;
  logic       bok = 1'b1;
  logic       dok = 1'b1;
  fbn_tg_t    tg;
  fbn_reply_t rep;
  logic [3:0] baud;
  logic       aen;
  logic [3:0] ncode;
  int         n_errors = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  fbn_kind_t   rk[17];
  logic [15:0] re[17];
  logic [31:0] rw[17];
  logic [33:0] rx[17];

  always #20 clk = ~clk;

  fbn_master_model mst (.i_clk(clk), .o_tg(tg));
  fbn_node #(.CRC_LIMIT(11)) dut (.i_clk(clk), .i_rst(rst), .i_tg(tg), .i_in_level(lvl), .i_sw_manual(man),
    .i_tens_code_switch(tens), .i_units_code_switch(units), .i_det_valid(det_v), .i_det_code(det_c),
    .i_nvm_load(nl), .i_nvm_code(nc), .i_nvm_bus_ok(bok), .i_nvm_data_ok(dok), .o_reply(rep),
    .o_baud_code(baud), .o_autobaud_en(aen), .o_nvm_store(), .o_nvm_code(ncode));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  task automatic tx(input fbn_kind_t k, input logic [7:0] st, input logic [15:0] el, input logic [31:0] wd,
                    input logic crc = 1'b1, input logic m = 1'b1);
    mst.send(k, st, el, wd, crc, m);
    #1;
  endtask : tx

  task automatic rd_st(input logic [31:0] e);
    tx(FBN_READ_REGISTER, 8'h17, REG_NODE_STATUS_WORD, 32'h0000_0000);
    chk("status", {2'b10, e}, rep);
  endtask : rd_st

  // Detected rate (d=1) or memory restore (d=0)
  task automatic pulse(input logic d, input logic [3:0] c);
    @(posedge clk);
    det_v <= d;
    nl    <= ~d;
    det_c <= c;
    nc    <= c;
    @(posedge clk);
    det_v <= 1'b0;
    nl    <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  task automatic row(input int i, input fbn_kind_t k, input logic [15:0] e, input logic [31:0] w,
                     input logic [33:0] x);
    rk[i] = k;
    re[i] = e;
    rw[i] = w;
    rx[i] = x;
  endtask : row

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      row(i, FBN_READ_INPUT, 16'(i + 1), 32'h0, {2'b10, 31'h0, i < 4 ? LVL[i] : MAN[i - 4]});
    end
    row(8, FBN_READ_REGISTER, 16'h0005, 32'h0, 34'h2_0000_0007);
    row(9, FBN_READ_REGISTER, 16'h0006, 32'h0, 34'h2_0000_0017);
    row(10, FBN_READ_OUTPUT, 16'h0001, 32'h0, NAK);
    row(11, FBN_WRITE_OUTPUT, 16'h0001, 32'h1, NAK);
    row(12, FBN_OTHER, 16'h0001, 32'h0, NAK);
    row(13, FBN_READ_INPUT, 16'h0009, 32'h0, NAK);
    row(14, FBN_WRITE_REGISTER, 16'h0006, 32'h3, NAK);
    row(15, FBN_WRITE_REGISTER, 16'h0005, 32'h3, NAK);
    row(16, FBN_READ_REGISTER, 16'h0003, 32'h0, NAK);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("baud", 34'(BAUD_9600), 34'(baud));
    rd_st(32'h0000_9300);
    for (int i = 0; i < 17; i++) begin
      tx(rk[i], 8'h17, re[i], rw[i]);
      chk("reply", rx[i], rep);
    end
    rd_st(32'h0000_932d);
    for (int c = 4; c <= 9; c++) begin
      tx(FBN_WRITE_REGISTER, 8'h17, REG_BAUD_RATE_SETTING, 32'(c));
      chk("ack", 34'h2, 34'(rep[33:32]));
      chk("baud", 34'(c), 34'(baud));
    end
    tx(FBN_WRITE_REGISTER, BROADCAST_ADDR, REG_BAUD_RATE_SETTING, 32'h8);
    chk("bcast reply", 34'h0, 34'(rep.valid));
    chk("bcast baud", 34'(BAUD_19200), 34'(baud));
    rd_st(32'h0000_932f);
    for (int n = 0; n < 10; n++) begin
      tx(FBN_READ_REGISTER, 8'h17, REG_NODE_STATUS_WORD, 32'h0, 1'b0);
      chk("crc reply", 34'h0, 34'(rep.valid));
    end
    @(posedge clk);
    #1;
    chk("armed early", 34'h0, 34'(aen));
    tx(FBN_READ_REGISTER, 8'h17, REG_NODE_STATUS_WORD, 32'h0, 1'b0);
    @(posedge clk);
    #1;
    chk("armed", 34'h1, 34'(aen));
    pulse(1'b1, BAUD_1200);
    chk("slow ignored", 34'h2_0000_0008, {aen, 29'h0, baud});
    pulse(1'b1, BAUD_4800);
    chk("detected", 34'h0_0000_0006, {aen, 29'h0, baud});
    chk("stored", 34'(BAUD_4800), 34'(ncode));
    rd_st(32'h0000_9324);
    tx(FBN_READ_REGISTER, 8'h17, REG_BAUD_RATE_SETTING, 32'h0, 1'b1, 1'b0);
    chk("slave read", 34'h2_0000_0006, rep);
    rd_st(32'h0000_9329);
    tx(FBN_READ_REGISTER, 8'h18, REG_BAUD_RATE_SETTING, 32'h0);
    chk("foreign", 34'h0, 34'(rep.valid));
    @(posedge clk);
    bok <= 1'b0;
    pulse(1'b0, BAUD_2400);
    chk("restored", 34'(BAUD_2400), 34'(baud));
    rd_st(32'h0000_962c);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset", 34'h0_0000_0007, {aen, 29'h0, baud});
    rd_st(32'h0000_9200);
    conclude();
  end
endmodule : tb

/* verilog/fbn_node.sv */
// Purpose: Telegram interpreter of a four-input field-bus node.
// Assumes: One decoded telegram per i_tg.valid pulse, framed by the link layer.
// Notes:   Replies come one clock after the telegram; the link layer sends them.
`timescale 1ns/1ps
module fbn_node
  import fbn_pkg::*;
#(
  parameter int CRC_LIMIT = CRC_ERR_LIMIT
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire fbn_tg_t    i_tg,
  input  wire logic [3:0] i_in_level,
  input  wire logic [3:0] i_sw_manual,
  input  wire logic [3:0] i_tens_code_switch,
  input  wire logic [3:0] i_units_code_switch,
  input  wire logic       i_det_valid,
  input  wire logic [3:0] i_det_code,
  input  wire logic       i_nvm_load,
  input  wire logic [3:0] i_nvm_code,
  input  wire logic       i_nvm_bus_ok,
  input  wire logic       i_nvm_data_ok,
  output fbn_reply_t      o_reply,
  output logic      [3:0] o_baud_code,
  output logic            o_autobaud_en,
  output logic            o_nvm_store,
  output logic      [3:0] o_nvm_code
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // The error counter is four bits wide
  if (CRC_LIMIT < 1 || CRC_LIMIT > 15) begin : g_bad_limit
    $error("CRC_LIMIT must lie between 1 and 15");
  end

  // Limit at the counter's own width
  localparam logic [3:0] CRC_LIMIT_C = 4'(CRC_LIMIT);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Registers and their next values
  fbn_reply_t  reply_r;
  logic [3:0]  baud_r;
  logic [3:0]  baud_nxt;
  logic        autobaud_r;
  logic        autobaud_nxt;
  logic [3:0]  crc_cnt_r;
  logic [3:0]  crc_cnt_nxt;
  logic        store_r;
  logic [3:0]  store_code_r;
  logic [7:0]  station_r;
  logic [3:0]  level_r;
  logic [3:0]  manual_r;
  logic        recog_r;
  logic        bcast_r;
  logic        master_r;
  logic        crc_ok_r;
  logic        running_r;
  logic        nvm_bus_r;
  logic        nvm_data_r;
  logic        from_nvm_r;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Station number from the two decimal switches; widen before the product so it cannot wrap
  wire logic [7:0] tens_weight = 8'(i_tens_code_switch) * 8'h0A;
  wire logic [7:0] units_value = 8'(i_units_code_switch);
  wire logic [7:0] sw_station  = tens_weight + units_value;

  // Broadcast only for the two write kinds
  wire logic is_write   = (i_tg.kind == FBN_WRITE_OUTPUT) || (i_tg.kind == FBN_WRITE_REGISTER);
  wire logic to_bcast   = is_write && (i_tg.station == BROADCAST_ADDR);
  wire logic to_own     = (i_tg.station == station_r);
  wire logic recognised = to_own || to_bcast;
  wire logic accept     = i_tg.valid && recognised && i_tg.crc_ok;

  // ---------------------------------------------------------------
  // Baud code decode
  // ---------------------------------------------------------------
  // Legal rate codes from telegram, memory and detector
  wire logic wr_code_ok = (i_tg.wdata >= 32'(BAUD_1200)) && (i_tg.wdata <= 32'(BAUD_38400));
  wire logic nvm_code_ok = (i_nvm_code >= BAUD_1200) && (i_nvm_code <= BAUD_38400);
  wire logic det_code_ok = (i_det_code >= BAUD_1200) && (i_det_code <= BAUD_38400);
  // The two slowest rates cannot follow a fast rate
  wire logic fast_now   = (baud_r == BAUD_19200) || (baud_r == BAUD_38400);
  wire logic det_slow   = (i_det_code == BAUD_1200) || (i_det_code == BAUD_2400);
  wire logic det_take   = autobaud_r && i_det_valid && det_code_ok && !(fast_now && det_slow);

  // ---------------------------------------------------------------
  // Status word assembly
  // ---------------------------------------------------------------
  // Status word, undefined positions forced low
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_RECOG]    = recog_r;
    status_word[ST_BCAST]    = bcast_r;
    status_word[ST_MASTER]   = master_r;
    status_word[ST_CRC_OK]   = crc_ok_r;
    status_word[ST_RUNNING]  = running_r;
    status_word[ST_NVM_BUS]  = nvm_bus_r;
    status_word[ST_NVM_DATA] = nvm_data_r;
    status_word[ST_NVM_BAUD] = from_nvm_r;
    status_word[ST_SW_AUTO +: 4] = ~manual_r;
  end

  // ---------------------------------------------------------------
  // Reply selection
  // ---------------------------------------------------------------
  // Element ranges and index of the addressed bit
  wire logic [15:0] elem = i_tg.elem;
  wire logic in_level = (elem >= ELEM_LEVEL_FIRST) && (elem <= ELEM_LEVEL_LAST);
  wire logic in_ovr   = (elem >= ELEM_OVR_FIRST) && (elem <= ELEM_OVR_LAST);
  wire logic [1:0] lvl_idx = 2'(elem - ELEM_LEVEL_FIRST);
  wire logic [1:0] ovr_idx = 2'(elem - ELEM_OVR_FIRST);
  wire logic wr_baud = (i_tg.kind == FBN_WRITE_REGISTER) && (elem == REG_BAUD_RATE_SETTING) && wr_code_ok;

  // Answer for the telegram now on the port; NAK unless a function exists
  logic        rsp_nak;
  logic [31:0] rsp_data;
  always_comb begin
    rsp_nak  = 1'b1;
    rsp_data = 32'h0000_0000;
    unique case (i_tg.kind)
      FBN_READ_INPUT: begin
        if (in_level) begin
          rsp_nak  = 1'b0;
          rsp_data = {31'h0000_0000, level_r[lvl_idx]};
        end else if (in_ovr) begin
          rsp_nak  = 1'b0;
          rsp_data = {31'h0000_0000, manual_r[ovr_idx]};
        end
      end
      FBN_READ_REGISTER: begin
        if (elem == REG_BAUD_RATE_SETTING) begin
          rsp_nak  = 1'b0;
          rsp_data = {28'h000_0000, baud_r};
        end else if (elem == REG_STATION_ADDRESS) begin
          rsp_nak  = 1'b0;
          rsp_data = {24'h00_0000, station_r};
        end else if (elem == REG_NODE_STATUS_WORD) begin
          rsp_nak  = 1'b0;
          rsp_data = status_word;
        end
      end
      FBN_WRITE_REGISTER: begin
        rsp_nak = !wr_baud;
      end
      FBN_READ_OUTPUT, FBN_WRITE_OUTPUT, FBN_OTHER: begin
        rsp_nak = 1'b1;
      end
      default: begin
        rsp_nak = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Next baud rate and recognition control
  // ---------------------------------------------------------------
  wire logic master_crc_err = i_tg.valid && i_tg.from_master && !i_tg.crc_ok;
  wire logic master_crc_ok  = i_tg.valid && i_tg.from_master && i_tg.crc_ok;
  // Sources of a new rate, highest priority first; memory only fills an idle cycle
  wire logic wr_take  = accept && wr_baud;
  wire logic nvm_take = i_nvm_load && nvm_code_ok && !det_take && !wr_take;
  // End points of the consecutive-error counter
  wire logic crc_at_limit = (crc_cnt_r == CRC_LIMIT_C);
  wire logic crc_last     = (crc_cnt_r == CRC_LIMIT_C - 4'h1);

  // Next rate, recognition enable and error count
  always_comb begin
    baud_nxt     = baud_r;
    autobaud_nxt = autobaud_r;
    crc_cnt_nxt  = crc_cnt_r;
    if (master_crc_err && !crc_at_limit) begin
      crc_cnt_nxt = crc_cnt_r + 4'h1;
    end else if (master_crc_ok) begin
      crc_cnt_nxt = 4'h0;
    end
    if (master_crc_err && crc_last) begin
      autobaud_nxt = 1'b1;
    end
    if (det_take) begin
      baud_nxt     = i_det_code;
      autobaud_nxt = 1'b0;
      crc_cnt_nxt  = 4'h0;
    end else if (wr_take) begin
      baud_nxt = i_tg.wdata[3:0];
    end else if (nvm_take) begin
      baud_nxt = i_nvm_code;
    end
  end

  // ---------------------------------------------------------------
  // Baud rate, recognition and memory store
  // ---------------------------------------------------------------
  // Rate, enable and counter registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      baud_r     <= BAUD_DEFAULT;
      autobaud_r <= 1'b0;
      crc_cnt_r  <= 4'h0;
    end else begin
      baud_r     <= baud_nxt;
      autobaud_r <= autobaud_nxt;
      crc_cnt_r  <= crc_cnt_nxt;
    end
  end

  // Store every change of rate except one just loaded from memory
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      store_r      <= 1'b0;
      store_code_r <= BAUD_DEFAULT;
      from_nvm_r   <= 1'b0;
    end else begin
      store_r      <= (det_take || wr_take) && baud_nxt != baud_r;
      store_code_r <= baud_nxt;
      if (nvm_take) begin
        from_nvm_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Input sampling
  // ---------------------------------------------------------------
  // Switches, inputs and memory health, registered once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      station_r  <= 8'h00;
      level_r    <= 4'h0;
      manual_r   <= 4'h0;
      nvm_bus_r  <= 1'b0;
      nvm_data_r <= 1'b0;
    end else begin
      station_r  <= sw_station;
      level_r    <= i_in_level;
      manual_r   <= i_sw_manual;
      nvm_bus_r  <= i_nvm_bus_ok;
      nvm_data_r <= i_nvm_data_ok;
    end
  end

  // ---------------------------------------------------------------
  // Last-transmission status
  // ---------------------------------------------------------------
  // An accepted read of the status word ends the reset indication
  wire logic rd_status = accept && (i_tg.kind == FBN_READ_REGISTER) && (elem == REG_NODE_STATUS_WORD);

  // Record how the latest telegram looked on the bus
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      recog_r   <= 1'b0;
      bcast_r   <= 1'b0;
      master_r  <= 1'b0;
      crc_ok_r  <= 1'b0;
      running_r <= 1'b0;
    end else begin
      if (i_tg.valid) begin
        recog_r  <= recognised && i_tg.crc_ok;
        bcast_r  <= to_bcast;
        master_r <= i_tg.from_master;
        crc_ok_r <= i_tg.crc_ok;
      end
      // Reset indication stays visible until status has been read once
      if (rd_status) begin
        running_r <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Reply register
  // ---------------------------------------------------------------
  // Broadcasts are carried out but never answered
  wire logic reply_due = accept && !to_bcast;

  // Hold the answer for exactly one cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reply_r <= '0;
    end else begin
      reply_r.valid <= reply_due;
      reply_r.nak   <= rsp_nak;
      reply_r.data  <= rsp_data;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Every output straight from its register
  assign o_reply       = reply_r;
  assign o_baud_code   = baud_r;
  assign o_autobaud_en = autobaud_r;
  assign o_nvm_store   = store_r;
  assign o_nvm_code    = store_code_r;

endmodule : fbn_node

/* verilog/fbn_pkg.sv */
// Purpose: Shared constants and carrier types for the field-bus input node.
// Assumes: Telegrams arrive already framed and CRC-checked by a link layer.
// Notes:   The rule summary below describes the node's behaviour.
//
// Behaviour
// - Accept every telegram type; answer types without function here with NAK.
// - After 11 consecutive master telegrams with CRC errors, enable baud recognition.
// - Output-write and register-write to station 255 are broadcasts.
// - Input read, elements 1 to 4, return input levels (1 = high).
// - Input read, elements 5 to 8, return override state (1 = manual).
// - Register read: 5 gives baud, 6 station address, 10 status word.
// - Status bit 0: node recognised the last transmission.
// - Status bit 1: last transmission was a broadcast.
// - Status bit 2: last transmission came from the master.
// - Status bit 3: CRC of the last message was correct.
// - Status bit 5 reads 0 after internal reset, 1 in normal operation.
// - Status bits 8 and 9 report memory bus and memory data health.
// - Status bit 10: baud loaded from memory; 0 means default 9600.
// - Status bits 12 to 15: override switch 1 to 4 on automatic.
// - Undefined status bits always read zero.
// - Register 5 write codes 4 to 9 select 1200 to 38400 baud.
// - The node starts at 9600 baud.
// - Station address comes from the decimal code switches.
// - The last baud rate is kept in non-volatile memory and restored.
// - At 19200 or 38400, recognition ignores 1200 and 2400 traffic.
// - Traffic uses parity transfer mode up to 38400 bit per second.
package fbn_pkg;

  // ---------------------------------------------------------------
  // Register map and element ranges
  // ---------------------------------------------------------------
  localparam logic [15:0] REG_BAUD_RATE_SETTING = 16'h0005;
  localparam logic [15:0] REG_STATION_ADDRESS   = 16'h0006;
  localparam logic [15:0] REG_NODE_STATUS_WORD  = 16'h000A;
  localparam logic [15:0] ELEM_LEVEL_FIRST      = 16'h0001;
  localparam logic [15:0] ELEM_LEVEL_LAST       = 16'h0004;
  localparam logic [15:0] ELEM_OVR_FIRST        = 16'h0005;
  localparam logic [15:0] ELEM_OVR_LAST         = 16'h0008;
  localparam logic [7:0]  BROADCAST_ADDR        = 8'hFF;

  // ---------------------------------------------------------------
  // Baud codes, reset values and counts
  // ---------------------------------------------------------------
  localparam logic [3:0]  BAUD_1200    = 4'h4;
  localparam logic [3:0]  BAUD_2400    = 4'h5;
  localparam logic [3:0]  BAUD_4800    = 4'h6;
  localparam logic [3:0]  BAUD_9600    = 4'h7;
  localparam logic [3:0]  BAUD_19200   = 4'h8;
  localparam logic [3:0]  BAUD_38400   = 4'h9;
  localparam logic [3:0]  BAUD_DEFAULT = BAUD_9600;
  localparam int          CRC_ERR_LIMIT = 11;

  // ---------------------------------------------------------------
  // Status word bit positions
  // ---------------------------------------------------------------
  localparam int ST_RECOG    = 0;
  localparam int ST_BCAST    = 1;
  localparam int ST_MASTER   = 2;
  localparam int ST_CRC_OK   = 3;
  localparam int ST_RUNNING  = 5;
  localparam int ST_NVM_BUS  = 8;
  localparam int ST_NVM_DATA = 9;
  localparam int ST_NVM_BAUD = 10;
  localparam int ST_SW_AUTO  = 12;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FBN_READ_INPUT,
    FBN_READ_OUTPUT,
    FBN_READ_REGISTER,
    FBN_WRITE_OUTPUT,
    FBN_WRITE_REGISTER,
    FBN_OTHER
  } fbn_kind_t;

  typedef struct packed {
    logic        valid;
    fbn_kind_t   kind;
    logic [7:0]  station;
    logic [15:0] elem;
    logic [31:0] wdata;
    logic        crc_ok;
    logic        from_master;
  } fbn_tg_t;

  typedef struct packed {
    logic        valid;
    logic        nak;
    logic [31:0] data;
  } fbn_reply_t;

endpackage : fbn_pkg
